// ---- rtl/rfc_config_regs.sv ----
// configuration and status register bank of the packet framer and rf control
// assumes an spi master: mode 0, msb first, sclk idles low, cs held high >= 200 ns
// between frames; tx/rx/ack events and clock sources come from logic on clk
//
// How it works
// [R1] calibrate oscillator at each tx/rx when enabled
// [R2] five-bit sleep regulator current select held
// [R3] read-only revision word with rf/digital fields
// [R4] preamble length one to eight bytes
// [R5] sync length and sync word selection
// [R6] tail length four plus two per code
// [R7] code zero selects nrz line coding
// [R8] code two selects two-thirds rate correction
// [R9] aux clock pin source select, default divide-by-four
// [R10] write-only sleep bit enters sleep, regs kept
// [R11] slave select low wakes device
// [R12] crystal kept running in sleep when set
// [R13] retransmissions limited by four-bit retry limit
// [R14] serial output driven or floated when deselected
// [R15] host programs nonzero equal whitening seed
// [R16] all registers reached over spi slave
// [R17] read-only and reserved bits ignore writes
module rfc_config_regs
    import rfc_pkg::*;
#(
    parameter logic [3:0]  RF_REV_ID  = 4'h1,    // arbitrary value
    parameter logic [2:0]  DIG_REV_ID = 3'h1,    // arbitrary value
    parameter logic [15:0] SIG_A      = 16'h5a5a, // arbitrary value
    parameter logic [15:0] SIG_B      = 16'ha5a5  // arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    // spi link
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_b,
    input  wire logic        spi_mosi,
    output logic             spi_miso_q,
    output logic             spi_miso_oe_b_q,
    // radio sequencer events
    input  wire logic        tx_start,
    input  wire logic        rx_start,
    input  wire logic        auto_ack_en,
    input  wire logic        ack_seen,
    input  wire logic        ack_timeout,
    input  wire logic        xtal_ready,
    // clock sources for the aux pin
    input  wire logic        xtal_ref,
    input  wire logic        tx_bit_clock,
    input  wire logic        synthesizer_clock,
    input  wire logic        trx_active,
    // control outputs
    output logic             cal_start_q,
    output logic [4:0]       sleep_regulator_current_sel_q,
    output logic [3:0]       preamble_bytes_q,
    output logic [6:0]       sync_bits_q,
    output logic [3:0]       sync_word_use_q,
    output logic [4:0]       tail_bits_q,
    output logic             nrz_en_q,
    output logic             two_thirds_rate_code_q,
    output logic             aux_clock_out_q,
    output logic             sleep_active_q,
    output logic             xtal_gain_en_q,
    output logic             xtal_run_q,
    output logic             osc_restart_q,
    output logic             retransmit_q,
    output logic             retry_exhausted_q,
    output logic [6:0]       whitening_seed_q
);

    logic            cal_en_q;
    logic [4:0]      ldo_sel_q;
    logic [2:0]      pre_sel_q;
    logic [1:0]      sync_sel_q;
    logic [2:0]      tail_sel_q;
    logic [1:0]      line_sel_q;
    logic [1:0]      fec_sel_q;
    logic [2:0]      aux_sel_q;
    logic            keepx_q;
    logic [3:0]      retry_limit_q;
    logic            drive_opt_q;
    logic [6:0]      seed_q;

    logic [4:0]      bit_cnt_q;
    logic [22:0]     in_sh_q;
    logic [7:0]      addr_q;
    logic [15:0]     wdata_q;
    logic            wr_done_q;
    logic            rd_req_q;
    logic [15:0]     out_sh_q;

    logic [2:0]      cs_sync_q;
    logic [2:0]      wr_sync_q;
    logic [2:0]      rd_sync_q;
    logic            wr_evt;
    logic            rd_evt;
    logic            cs_fall;
    logic [15:0]     rd_hold_q;

    rfc_pwr_t        pwr_q;
    logic [3:0]      retry_cnt_q;
    logic            xref_q;
    logic [3:0]      div_cnt_q;

    function automatic logic [15:0] reg_read(input logic [6:0] idx);
        logic [15:0] w;
        w = 16'h0000;
        case (idx)
            OFS_OSC_CAL:   w[CAL_EN_BIT] = cal_en_q;
            OFS_SLEEP_REG: w[LDO_LSB +: 5] = ldo_sel_q;
            OFS_REVISION: begin
                w[REV_RF_LSB +: 4]  = RF_REV_ID;   // [R3]
                w[REV_DIG_LSB +: 3] = DIG_REV_ID;  // [R3]
            end
            OFS_SIG_A:     w = SIG_A;
            OFS_SIG_B:     w = SIG_B;
            OFS_FRAME: begin
                w[PRE_LSB +: 3]  = pre_sel_q;
                w[SYNC_LSB +: 2] = sync_sel_q;
                w[TAIL_LSB +: 3] = tail_sel_q;
                w[LINE_LSB +: 2] = line_sel_q;
                w[FEC_LSB +: 2]  = fec_sel_q;
                w[AUX_LSB +: 3]  = aux_sel_q;
            end
            OFS_PWR: begin
                w[KEEPX_BIT]     = keepx_q;
                w[RETRY_LSB +: 4] = retry_limit_q;
                w[DRV_BIT]       = drive_opt_q;
                w[SEED_LSB +: 7] = seed_q;
            end
            default:       w = 16'h0000;
        endcase
        return w;
    endfunction

    // frame shift-in; cs high clears the frame state
    always_ff @(posedge spi_sclk or posedge spi_cs_b) begin
        if (spi_cs_b) begin
            bit_cnt_q <= 5'h00;
            wr_done_q <= 1'b0;
            rd_req_q  <= 1'b0;
        end else begin
            if (bit_cnt_q != SPI_CNT_MAX) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            if (bit_cnt_q == SPI_ADDR_LAST && in_sh_q[6]) begin
                rd_req_q <= 1'b1;                                  // [R16]
            end
            if (bit_cnt_q == SPI_WR_LAST && !addr_q[7]) begin
                wr_done_q <= 1'b1;                                 // [R16]
            end
        end
    end

    // data path of the frame, held stable until the next frame's clocks
    always_ff @(posedge spi_sclk) begin
        in_sh_q <= {in_sh_q[21:0], spi_mosi};
        if (!spi_cs_b && bit_cnt_q == SPI_ADDR_LAST) begin
            addr_q <= {in_sh_q[6:0], spi_mosi};
        end
        if (!spi_cs_b && bit_cnt_q == SPI_WR_LAST && !addr_q[7]) begin
            wdata_q <= {in_sh_q[14:0], spi_mosi};
        end
    end

    // read data out on falling edges; rd_hold_q settled during the pad byte
    always_ff @(negedge spi_sclk or posedge spi_cs_b) begin
        if (spi_cs_b) begin
            out_sh_q   <= 16'h0000;
            spi_miso_q <= 1'b0;
        end else if (bit_cnt_q == SPI_RD_LOAD) begin
            spi_miso_q <= rd_hold_q[15];                           // [R16]
            out_sh_q   <= {rd_hold_q[14:0], 1'b0};
        end else begin
            spi_miso_q <= out_sh_q[15];
            out_sh_q   <= {out_sh_q[14:0], 1'b0};
        end
    end

    // level synchronisers into clk
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cs_sync_q <= 3'h7;
            wr_sync_q <= 3'h0;
            rd_sync_q <= 3'h0;
        end else begin
            cs_sync_q <= {cs_sync_q[1:0], spi_cs_b};
            wr_sync_q <= {wr_sync_q[1:0], wr_done_q};
            rd_sync_q <= {rd_sync_q[1:0], rd_req_q};
        end
    end

    assign wr_evt  = wr_sync_q[1] & ~wr_sync_q[2];
    assign rd_evt  = rd_sync_q[1] & ~rd_sync_q[2];
    assign cs_fall = ~cs_sync_q[1] & cs_sync_q[2];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_hold_q <= 16'h0000;
        end else if (rd_evt) begin
            rd_hold_q <= reg_read(addr_q[6:0]);                    // [R16]
        end
    end

    // register writes; only documented writable fields are stored
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cal_en_q      <= CAL_RST;
            ldo_sel_q     <= LDO_RST;
            pre_sel_q     <= PRE_RST;
            sync_sel_q    <= SYNC_RST;
            tail_sel_q    <= TAIL_RST;
            line_sel_q    <= LINE_RST;
            fec_sel_q     <= FEC_RST;
            aux_sel_q     <= AUX_RST;
            keepx_q       <= KEEPX_RST;
            retry_limit_q <= RETRY_RST;
            drive_opt_q   <= DRV_RST;
            seed_q        <= SEED_RST;
        end else if (wr_evt) begin
            case (addr_q[6:0])
                OFS_OSC_CAL:   cal_en_q  <= wdata_q[CAL_EN_BIT];   // [R1]
                OFS_SLEEP_REG: ldo_sel_q <= wdata_q[LDO_LSB +: 5]; // [R2]
                OFS_FRAME: begin
                    pre_sel_q  <= wdata_q[PRE_LSB +: 3];           // [R4]
                    sync_sel_q <= wdata_q[SYNC_LSB +: 2];          // [R5]
                    tail_sel_q <= wdata_q[TAIL_LSB +: 3];          // [R6]
                    line_sel_q <= wdata_q[LINE_LSB +: 2];          // [R7]
                    fec_sel_q  <= wdata_q[FEC_LSB +: 2];           // [R8]
                    aux_sel_q  <= wdata_q[AUX_LSB +: 3];           // [R9]
                end
                OFS_PWR: begin
                    keepx_q       <= wdata_q[KEEPX_BIT];           // [R12]
                    retry_limit_q <= wdata_q[RETRY_LSB +: 4];      // [R13]
                    drive_opt_q   <= wdata_q[DRV_BIT];             // [R14]
                    seed_q        <= wdata_q[SEED_LSB +: 7];       // [R15]
                end
                default: ;                                         // [R17]
            endcase
        end
    end

    // sleep and wake sequencing
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pwr_q         <= PWR_RUN;
            osc_restart_q <= 1'b0;
        end else begin
            osc_restart_q <= 1'b0;
            case (pwr_q)
                PWR_RUN: begin
                    if (wr_evt && addr_q[6:0] == OFS_PWR && wdata_q[SLEEP_BIT]) begin
                        pwr_q <= PWR_SLEEP;                        // [R10]
                    end
                end
                PWR_SLEEP: begin
                    if (cs_fall) begin
                        pwr_q         <= PWR_WAKE;                 // [R11]
                        osc_restart_q <= 1'b1;                     // [R11]
                    end else if (wr_evt && addr_q[6:0] == OFS_PWR
                                 && !wdata_q[SLEEP_BIT]) begin
                        pwr_q <= PWR_RUN;                          // [R10]
                    end
                end
                PWR_WAKE: begin
                    if (keepx_q || xtal_ready) begin
                        pwr_q <= PWR_RUN;                          // [R12]
                    end
                end
                default: pwr_q <= PWR_RUN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sleep_active_q <= 1'b0;
            xtal_gain_en_q <= 1'b1;
            xtal_run_q     <= 1'b1;
        end else begin
            sleep_active_q <= (pwr_q == PWR_SLEEP);                // [R10]
            xtal_gain_en_q <= (pwr_q != PWR_SLEEP);                // [R10]
            xtal_run_q     <= (pwr_q != PWR_SLEEP) || keepx_q;     // [R12]
        end
    end

    // calibration trigger
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cal_start_q <= 1'b0;
        end else begin
            cal_start_q <= cal_en_q && (tx_start || rx_start)
                           && (pwr_q == PWR_RUN);                  // [R1]
        end
    end

    // decoded framer settings
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sleep_regulator_current_sel_q <= LDO_RST;
            preamble_bytes_q       <= 4'h0;
            sync_bits_q            <= 7'h00;
            sync_word_use_q        <= 4'h0;
            tail_bits_q            <= 5'h00;
            nrz_en_q               <= 1'b0;
            two_thirds_rate_code_q <= 1'b0;
            whitening_seed_q       <= SEED_RST;
        end else begin
            sleep_regulator_current_sel_q <= ldo_sel_q;            // [R2]
            preamble_bytes_q <= {1'b0, pre_sel_q} + 4'h1;          // [R4]
            sync_bits_q      <= {3'h0, sync_sel_q, 2'h0} * 7'h04
                                + 7'h10;                           // [R5]
            case (sync_sel_q)
                2'h3:    sync_word_use_q <= 4'hf;                  // [R5]
                2'h2:    sync_word_use_q <= 4'hd;
                2'h1:    sync_word_use_q <= 4'h9;
                default: sync_word_use_q <= 4'h1;
            endcase
            tail_bits_q <= {1'b0, tail_sel_q, 1'b0} + 5'h04;       // [R6]
            nrz_en_q    <= (line_sel_q == LINE_NRZ);               // [R7]
            two_thirds_rate_code_q <= (fec_sel_q == FEC_TWO_THIRDS); // [R8]
            whitening_seed_q <= seed_q;                            // [R15]
        end
    end

    // aux clock dividers counted on rising edges of the crystal reference
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            xref_q    <= 1'b0;
            div_cnt_q <= 4'h0;
        end else begin
            xref_q <= xtal_ref;
            if (xtal_ref && !xref_q) begin
                div_cnt_q <= (div_cnt_q == DIV12_WRAP) ? 4'h0 : div_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aux_clock_out_q <= 1'b0;
        end else begin
            case (aux_sel_q)
                AUX_XTAL:  aux_clock_out_q <= xtal_ref;            // [R9]
                AUX_DIV2:  aux_clock_out_q <= div_cnt_q[0];        // [R9]
                AUX_DIV4:  aux_clock_out_q <= div_cnt_q[1];        // [R9]
                AUX_DIV12: aux_clock_out_q <= (div_cnt_q < DIV12_HALF); // [R9]
                AUX_TX_BIT_CLOCK: aux_clock_out_q <= tx_bit_clock;        // [R9]
                AUX_SYNTH: aux_clock_out_q <= synthesizer_clock && trx_active; // [R9]
                default:   aux_clock_out_q <= 1'b0;                // [R9]
            endcase
        end
    end

    // retry limiter, active only with automatic acknowledgement
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            retry_cnt_q       <= 4'h0;
            retransmit_q      <= 1'b0;
            retry_exhausted_q <= 1'b0;
        end else begin
            retransmit_q      <= 1'b0;
            retry_exhausted_q <= 1'b0;
            if (ack_seen || !auto_ack_en) begin
                retry_cnt_q <= 4'h0;
            end else if (ack_timeout) begin
                if (retry_cnt_q < retry_limit_q) begin
                    retry_cnt_q  <= retry_cnt_q + 4'h1;            // [R13]
                    retransmit_q <= 1'b1;                          // [R13]
                end else begin
                    retry_cnt_q       <= 4'h0;
                    retry_exhausted_q <= 1'b1;                     // [R13]
                end
            end
        end
    end

    // miso enable, active low: driven in frame or when the option is set
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            spi_miso_oe_b_q <= 1'b1;
        end else begin
            spi_miso_oe_b_q <= cs_sync_q[1] && !drive_opt_q;       // [R14]
        end
    end

endmodule

// ---- rtl/rfc_pkg.sv ----
// constants for the radio framer configuration register bank
// assumes a 7-bit register index carried in the first byte of each spi frame
package rfc_pkg;

    // register indices
    localparam logic [6:0] OFS_OSC_CAL   = 7'h17;
    localparam logic [6:0] OFS_SLEEP_REG = 7'h1b;
    localparam logic [6:0] OFS_REVISION  = 7'h1d;
    localparam logic [6:0] OFS_SIG_A     = 7'h1e;
    localparam logic [6:0] OFS_SIG_B     = 7'h1f;
    localparam logic [6:0] OFS_FRAME     = 7'h20;
    localparam logic [6:0] OFS_PWR       = 7'h23;

    // field positions
    localparam int CAL_EN_BIT   = 2;
    localparam int LDO_LSB      = 11;
    localparam int REV_RF_LSB   = 4;
    localparam int REV_DIG_LSB  = 0;
    localparam int PRE_LSB      = 13;
    localparam int SYNC_LSB     = 11;
    localparam int TAIL_LSB     = 8;
    localparam int LINE_LSB     = 6;
    localparam int FEC_LSB      = 4;
    localparam int AUX_LSB      = 1;
    localparam int SLEEP_BIT    = 14;
    localparam int KEEPX_BIT    = 12;
    localparam int RETRY_LSB    = 8;
    localparam int DRV_BIT      = 7;
    localparam int SEED_LSB     = 0;

    // reset values
    localparam logic       CAL_RST   = 1'b0;
    localparam logic [4:0] LDO_RST   = 5'h00;
    localparam logic [2:0] PRE_RST   = 3'h2;
    localparam logic [1:0] SYNC_RST  = 2'h3;
    localparam logic [2:0] TAIL_RST  = 3'h0;
    localparam logic [1:0] LINE_RST  = 2'h0;
    localparam logic [1:0] FEC_RST   = 2'h0;
    localparam logic [2:0] AUX_RST   = 3'h3;
    localparam logic       KEEPX_RST = 1'b1;
    localparam logic [3:0] RETRY_RST = 4'h3;
    localparam logic       DRV_RST   = 1'b0;
    localparam logic [6:0] SEED_RST  = 7'h00;

    // encodings
    localparam logic [1:0] LINE_NRZ       = 2'h0;
    localparam logic [1:0] FEC_TWO_THIRDS = 2'h2;
    localparam logic [2:0] AUX_XTAL       = 3'h1;
    localparam logic [2:0] AUX_DIV2       = 3'h2;
    localparam logic [2:0] AUX_DIV4       = 3'h3;
    localparam logic [2:0] AUX_DIV12      = 3'h4;
    localparam logic [2:0] AUX_TX_BIT_CLOCK      = 3'h5;
    localparam logic [2:0] AUX_SYNTH      = 3'h6;
    localparam logic [3:0] DIV12_WRAP     = 4'hb;
    localparam logic [3:0] DIV12_HALF     = 4'h6;

    // spi frame bit counts: address byte, read pad byte, data word
    localparam logic [4:0] SPI_ADDR_LAST = 5'h07;
    localparam logic [4:0] SPI_RD_LOAD   = 5'h10;
    localparam logic [4:0] SPI_WR_LAST   = 5'h17;
    localparam logic [4:0] SPI_CNT_MAX   = 5'h1f;

    typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_WAKE} rfc_pwr_t;

endpackage

// ---- tb/rfc_config_regs_chk.sv ----
// assertions on the ports of the configuration register bank
// assumes one clk domain with synchronous active-low reset
module rfc_config_regs_chk (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       spi_cs_b,
    input wire logic       spi_miso_q,
    input wire logic       spi_miso_oe_b_q,
    input wire logic       tx_start,
    input wire logic       rx_start,
    input wire logic       ack_timeout,
    input wire logic       cal_start_q,
    input wire logic [6:0] sync_bits_q,
    input wire logic [3:0] sync_word_use_q,
    input wire logic [4:0] tail_bits_q,
    input wire logic       sleep_active_q,
    input wire logic       xtal_gain_en_q,
    input wire logic       xtal_run_q,
    input wire logic       osc_restart_q,
    input wire logic       retransmit_q,
    input wire logic       retry_exhausted_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_cal;
        cal_start_q |-> $past(tx_start || rx_start) && !$past(sleep_active_q);
    endproperty
    a_cal: assert property (p_cal) else $error("calibration without a start");
    property p_sync;
        sync_bits_q != 7'h00 |-> sync_bits_q[3:0] == 4'h0 && sync_word_use_q ==
            {sync_bits_q >= 7'h20, sync_bits_q >= 7'h30, sync_bits_q == 7'h40, 1'b1};
    endproperty
    a_sync: assert property (p_sync) else $error("sync length and words disagree");
    property p_tail;
        tail_bits_q != 5'h00 |-> !tail_bits_q[0] && tail_bits_q inside {[5'h04:5'h12]};
    endproperty
    a_tail: assert property (p_tail) else $error("tail length out of range");
    property p_gain;
        xtal_gain_en_q != sleep_active_q;
    endproperty
    a_gain: assert property (p_gain) else $error("crystal gain on in sleep");
    property p_xrun;
        !xtal_run_q |-> sleep_active_q;
    endproperty
    a_xrun: assert property (p_xrun) else $error("crystal stopped while awake");
    property p_wake;
        osc_restart_q |-> $past(sleep_active_q) ##[1:4] !sleep_active_q;
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not complete");
    property p_retry;
        retransmit_q |-> $past(ack_timeout) && !retry_exhausted_q;
    endproperty
    a_retry: assert property (p_retry) else $error("retransmit without timeout");
    property p_exh;
        retry_exhausted_q |-> $past(ack_timeout);
    endproperty
    a_exh: assert property (p_exh) else $error("retry limit flag without timeout");
    property p_oe;
        (!spi_cs_b) [*4] |-> !spi_miso_oe_b_q;
    endproperty
    a_oe: assert property (p_oe) else $error("serial output not driven when selected");
    property p_idle;
        spi_cs_b |-> !spi_miso_q;
    endproperty
    a_idle: assert property (p_idle) else $error("serial output not low when idle");
    c_cal: cover property (cal_start_q);
    c_wake: cover property (osc_restart_q);
    c_exh: cover property (retry_exhausted_q);
endmodule

bind rfc_config_regs rfc_config_regs_chk rfc_config_regs_chk_inst (
    .clk, .rst_b, .spi_cs_b, .spi_miso_q, .spi_miso_oe_b_q, .tx_start, .rx_start,
    .ack_timeout, .cal_start_q, .sync_bits_q, .sync_word_use_q, .tail_bits_q,
    .sleep_active_q, .xtal_gain_en_q, .xtal_run_q, .osc_restart_q, .retransmit_q,
    .retry_exhausted_q
);

// ---- tb/rfc_spi_host.sv ----
// spi master model standing in for the host controller
// assumes mode 0: device samples mosi on sclk rise, shifts miso on fall
module rfc_spi_host (
    output logic     spi_sclk,
    output logic     spi_cs_b,
    output logic     spi_mosi,
    input wire logic spi_miso_q
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        spi_sclk = 1'b0;
        spi_cs_b = 1'b0;
        spi_mosi = 1'b0;
        #1 spi_cs_b = 1'b1; // edge clears the frame state at start
    end
    // sclk runs only inside a frame, 64 ns period
    task automatic frame(input logic [31:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        spi_cs_b = 1'b0; // select also wakes a sleeping device
        #32;
        for (int i = 0; i < n; i++) begin
            spi_mosi = tx[31-i];
            #32 spi_sclk = 1'b1;
            rx = {rx[14:0], spi_miso_q};
            #32 spi_sclk = 1'b0;
        end
        #32 spi_cs_b = 1'b1;
        spi_mosi = ~spi_mosi; // released line shows no stale bit
        #400;
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] unused;
        frame({1'b0, a, d, 8'h00}, 24, unused);
    endtask
    task automatic rd(input logic [6:0] a, output logic [15:0] q);
        frame({1'b1, a, 24'h000000}, 32, q);
    endtask
endmodule

// ---- tb/test_radio_framer_config_regs.sv ----
// self-checking bench for the register bank and its spi access
// assumes rfc_spi_host plays the host and the checker is bound to the design
module test_radio_framer_config_regs;
    import rfc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] USE_TBL = 16'hfd91;
    localparam logic [22:0] RST_TBL [8] = '{{OFS_OSC_CAL, 16'h0000}, {OFS_SLEEP_REG, 16'h0000},
        {OFS_REVISION, 16'h0065}, {OFS_SIG_A, 16'h3c3c}, {OFS_SIG_B, 16'hc3c3},
        {OFS_FRAME, 16'h5806}, {OFS_PWR, 16'h1300}, {7'h05, 16'h0000}};
    localparam logic [38:0] WR_TBL [7] = '{{OFS_REVISION, 16'hffff, 16'h0065},
        {OFS_SIG_A, 16'h0000, 16'h3c3c}, {OFS_OSC_CAL, 16'hffff, 16'h0004},
        {OFS_SLEEP_REG, 16'hffff, 16'hf800}, {OFS_FRAME, 16'hffff, 16'hfffe},
        {OFS_PWR, 16'hbfff, 16'h1fff}, {7'h07, 16'h1234, 16'h0000}};
    localparam logic [6:0] AUX_TBL [6] = '{7'h70, 7'h7e, 7'h5b, 7'h3a, 7'h3d, 7'h6c};
    localparam logic [6:0] EVT_TBL [6] = '{7'h12, 7'h12, 7'h08, 7'h12, 7'h12, 7'h11};
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       xtal_ref = 1'b0;
    logic       auto_ack_en = 1'b1;
    logic [3:0] evt = 4'h0;
    logic [2:0] src = 3'h0;
    logic       spi_sclk, spi_cs_b, spi_mosi, spi_miso_q, spi_miso_oe_b_q;
    logic       cal_start_q, nrz_en_q, two_thirds_rate_code_q, aux_clock_out_q;
    logic       sleep_active_q, xtal_gain_en_q, xtal_run_q, osc_restart_q;
    logic       retransmit_q, retry_exhausted_q;
    logic [3:0] preamble_bytes_q, sync_word_use_q;
    logic [4:0] sleep_regulator_current_sel_q, tail_bits_q;
    logic [6:0] sync_bits_q, whitening_seed_q;
    logic [15:0] rdata;
    int         miscompares = 0;
    int         checks_done = 0;
    int         cycles = 0;
    // undriven miso shows a changing pattern
    wire        miso_line = spi_miso_oe_b_q ? cycles[0] : spi_miso_q;
    // identity values are arbitrary
    rfc_config_regs #(.RF_REV_ID(4'h6), .DIG_REV_ID(3'h5), .SIG_A(16'h3c3c), .SIG_B(16'hc3c3))
        rfc_config_regs_inst (.clk, .rst_b, .spi_sclk, .spi_cs_b, .spi_mosi, .spi_miso_q,
        .spi_miso_oe_b_q, .tx_start(evt[3]), .rx_start(evt[2]), .auto_ack_en,
        .ack_seen(evt[0]), .ack_timeout(evt[1]), .xtal_ready(1'b1), .xtal_ref,
        .tx_bit_clock(src[2]), .synthesizer_clock(src[1]), .trx_active(src[0]), .cal_start_q,
        .sleep_regulator_current_sel_q, .preamble_bytes_q, .sync_bits_q, .sync_word_use_q,
        .tail_bits_q, .nrz_en_q, .two_thirds_rate_code_q, .aux_clock_out_q, .sleep_active_q,
        .xtal_gain_en_q, .xtal_run_q, .osc_restart_q, .retransmit_q, .retry_exhausted_q,
        .whitening_seed_q);
    rfc_spi_host rfc_spi_host_inst (.spi_sclk, .spi_cs_b, .spi_mosi, .spi_miso_q(miso_line));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one-cycle event pulse, flags compared while they stand
    task automatic pulse(input logic [3:0] e, input logic [2:0] exp);
        @(posedge clk);
        #1 evt = e;
        @(posedge clk);
        #1 evt = 4'h0;
        chk(16'({cal_start_q, retransmit_q, retry_exhausted_q}), 16'(exp));
    endtask
    always #25 clk = ~clk;
    always @(posedge clk) #1 xtal_ref = ~xtal_ref;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rfc_spi_host_inst.rd(RST_TBL[i][22:16], rdata);
            chk(rdata, RST_TBL[i][15:0]);
        end
        $display("reset values done");
        for (int i = 0; i < 7; i++) begin
            rfc_spi_host_inst.wr(WR_TBL[i][38:32], WR_TBL[i][31:16]);
            rfc_spi_host_inst.rd(WR_TBL[i][38:32], rdata);
            chk(rdata, WR_TBL[i][15:0]);
        end
        chk(16'({sleep_regulator_current_sel_q, whitening_seed_q}), 16'h0fff);
        $display("access kinds done");
        for (int i = 0; i < 8; i++) begin
            rfc_spi_host_inst.wr(OFS_FRAME, {i[2:0], i[1:0], i[2:0], i[1:0], i[1:0], 4'h6});
            if (i < 3)
                chk(16'(preamble_bytes_q), 16'(i + 1));
            chk(16'({sync_bits_q, sync_word_use_q}),
                16'({7'(16 * (i % 4 + 1)), USE_TBL[4 * (i % 4) +: 4]}));
            chk(16'(tail_bits_q), 16'(4 + 2 * i));
            chk(16'({nrz_en_q, two_thirds_rate_code_q}), 16'({i % 4 == 0, i % 4 == 2}));
        end
        $display("frame format decode done");
        for (int i = 0; i < 6; i++) begin
            src = AUX_TBL[i][6:4];
            rfc_spi_host_inst.wr(OFS_FRAME, {12'h580, AUX_TBL[i][3:1], 1'b0});
            chk(16'(aux_clock_out_q), 16'(AUX_TBL[i][0]));
        end
        $display("aux clock select done");
        pulse(4'h8, 3'h4);
        pulse(4'h4, 3'h4);
        rfc_spi_host_inst.wr(OFS_OSC_CAL, 16'h0000);
        pulse(4'h8, 3'h0);
        rfc_spi_host_inst.wr(OFS_PWR, 16'h1205); // nonzero seed
        for (int i = 0; i < 6; i++)
            pulse(EVT_TBL[i][6:3], EVT_TBL[i][2:0]);
        auto_ack_en = 1'b0;
        pulse(4'h2, 3'h0);
        $display("calibration and retry done");
        rfc_spi_host_inst.wr(OFS_PWR, 16'h5385);
        chk(16'({sleep_active_q, xtal_gain_en_q, xtal_run_q, spi_miso_oe_b_q}), 16'ha);
        rfc_spi_host_inst.rd(OFS_PWR, rdata);
        chk(rdata, 16'h1385);
        chk(16'({sleep_active_q, xtal_gain_en_q, xtal_run_q, spi_miso_oe_b_q}), 16'h6);
        rfc_spi_host_inst.wr(OFS_PWR, 16'h4305);
        chk(16'({sleep_active_q, xtal_gain_en_q, xtal_run_q, spi_miso_oe_b_q}), 16'h9);
        rfc_spi_host_inst.rd(OFS_PWR, rdata);
        chk(rdata, 16'h0305);
        chk(16'({sleep_active_q, xtal_gain_en_q, xtal_run_q, whitening_seed_q}), 16'h0185);
        $display("sleep and wake done");
        tally_and_finish();
    end
endmodule
